// ---- pmc_pkg.sv ----
/*
 * Shared constants, register map and types of the power mode controller.
 * Assumes one 250 MHz clock and an APB master with 32-bit data.
 */
// Operation
// - Always exactly one of four power modes.
// - Good system supply returns any other mode to mission next cycle.
// - Supply drop clears the supply-good status.
// - Supply loss: battery, event pulse, status update.
// - MPU keeps running from mission into brownout.
// - Compute engine keeps running in brownout.
// - PLL speed unchanged by brownout entry from mission.
// - Peripherals stay enabled in brownout.
// - Firmware may request display-only or sleep.
// - Supply return: mission, system power, event.
// - Wake events move display-only or sleep to brownout.
// - Display-only bit commands display-only mode.
// - Display-only from mission wakes at once.
// - Display-only: rail off, MPU off, segments driven.
// - Two segments blink without the MPU.
// - Leaving low power restarts MPU, resets config.
// - Sleep bit in brownout enters sleep.
// - Sleep mode disconnects the digital rail.
// - Sleep left only by power or wake.
// - Sleep with supply present bounces to mission.
// - Watchdog held reset while wake is low.
package pmc_pkg;

    typedef enum logic [1:0]
    {
        MODE_MISSION = 2'b00,
        MODE_BROWNOUT = 2'b01,
        MODE_DISPLAY = 2'b10,
        MODE_SLEEP = 2'b11
    } mode_t;

    // The upper mode bit marks the two modes that drop the digital rail.
    localparam int MODE_LOW_BIT = 1;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] EVENT_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] SEG_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] TIMER_OFS = 8'h10;

    localparam int CTL_W = 6;
    localparam int CTL_DISPLAY_BIT = 0;
    localparam int CTL_SLEEP_BIT = 1;
    localparam int CTL_PLL_FAST_BIT = 2;
    localparam int CTL_CE_RUN_BIT = 3;
    localparam int CTL_BLINK_A_BIT = 4;
    localparam int CTL_BLINK_B_BIT = 5;
    localparam logic [CTL_W-1:0] CTRL_RESET = 6'h0C;

    localparam int EV_W = 3;
    localparam int EV_LOST_BIT = 0;
    localparam int EV_BACK_BIT = 1;
    localparam int EV_WOKE_BIT = 2;

    localparam int STAT_W = 3;
    localparam logic [STAT_W-1:0] STAT_SYSTEM = 3'h1;
    localparam logic [STAT_W-1:0] STAT_BATTERY = 3'h2;

    // Pins: push button, wake pins a, b, c, serial receive, optical receive.
    localparam int PIN_W = 6;
    localparam logic [PIN_W-1:0] RISING_MASK = 6'h0F;
    // Sources: timer, push button, pins a, b, c, either serial input.
    localparam int WAKE_SRC_W = 6;

    localparam int SEG_W = 32;
    localparam int BLINK_A_IDX = 0;
    localparam int BLINK_B_IDX = 1;

    localparam int TMR_W = 16;
    localparam logic [TMR_W-1:0] TMR_LAST = 16'h0001;
    localparam int CNT_W = 32;

    localparam longint CLK_PERIOD_PS = 64'h0000_0000_0000_0FA0;
    localparam longint PS_PER_MS = 64'h0000_0000_3B9A_CA00;
    localparam longint TICK_MS = 64'h1;
    localparam longint BLINK_HALF_MS = 64'h1F4;
    localparam int TICK_CYCLES_DEF = int'((TICK_MS * PS_PER_MS) / CLK_PERIOD_PS);
    localparam int BLINK_HALF_CYCLES_DEF = int'((BLINK_HALF_MS * PS_PER_MS) / CLK_PERIOD_PS);

endpackage

// ---- pmc_wake_if.sv ----
/*
 * Carrier between the mode controller and the wake capture block.
 * Assumes both ends run on the same clock and reset.
 */
`timescale 1ns/1ps
interface pmc_wake_if
    import pmc_pkg::*;
();
    logic arm;
    logic timer_expired;
    logic supply_good;
    logic [WAKE_SRC_W-1:0] pending_src;

    modport capture
    (
        input arm,
        input timer_expired,
        output supply_good,
        output pending_src
    );

    modport ctrl
    (
        output arm,
        output timer_expired,
        input supply_good,
        input pending_src
    );
endinterface

// ---- wake_capture.sv ----
/*
 * Synchronises the supply comparator and wake pins, detects edges and
 * holds wake events while the controller arms it in low power.
 * Assumes pins are asynchronous to the clock.
 */
`timescale 1ns/1ps
module wake_capture
    import pmc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic supply_pin_i,
    input wire logic [PIN_W-1:0] pins_i,
    pmc_wake_if.capture wif
);
    // The supply flops reset high so that reset release does not fake a loss.
    localparam logic [PIN_W:0] SYNC_RESET = {1'h1, {PIN_W{1'h0}}};

    logic [PIN_W:0] meta_q;
    logic [PIN_W:0] sync_q;
    logic [PIN_W-1:0] prev_q;
    logic [PIN_W-1:0] edge_w;
    logic [WAKE_SRC_W-1:0] event_w;
    logic [WAKE_SRC_W-1:0] pend_q;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= SYNC_RESET;
            sync_q <= SYNC_RESET;
            prev_q <= '0;
        end
        else
        begin
            meta_q <= {supply_pin_i, pins_i};
            sync_q <= meta_q;
            prev_q <= sync_q[PIN_W-1:0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < PIN_W; g++)
        begin : g_edge
            // Serial inputs wake on any transition, the rest on a rising edge.
            assign edge_w[g] = RISING_MASK[g] ? (sync_q[g] & ~prev_q[g])
                                              : (sync_q[g] ^ prev_q[g]);
        end
    endgenerate

    assign event_w = {edge_w[5] | edge_w[4], edge_w[3:0], wif.timer_expired};
    assign wif.supply_good = sync_q[PIN_W];
    assign wif.pending_src = pend_q;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pend_q <= '0;
        else if (!wif.arm)
            pend_q <= '0;
        else
            pend_q <= pend_q | event_w;
    end

    a_wake_latch_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wif.arm && (|event_w)) |=> ((|pend_q) || !wif.arm))
        else $error("wake event lost while armed");
endmodule

// ---- power_mode_controller.sv ----
/*
 * Power mode sequencer with APB registers: mission, brownout,
 * display-only and sleep modes, supply events, rail gating, MPU restart,
 * wake timer and autonomous segment blink.
 * Assumes an APB master on CLK_I and asynchronous supply and wake pins.
 */
`timescale 1ns/1ps
module power_mode_controller
    import pmc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF,
    parameter int BLINK_HALF_CYCLES = BLINK_HALF_CYCLES_DEF
)
(
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [DATA_W-1:0] PWDATA_I,
    output logic [DATA_W-1:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic SUPPLY_GOOD_I,
    input wire logic PUSH_BUTTON_WAKE_I,
    input wire logic WAKE_PIN_A_I,
    input wire logic WAKE_PIN_B_I,
    input wire logic WAKE_PIN_C_I,
    input wire logic SERIAL_RX_I,
    input wire logic OPTICAL_RECEIVE_INPUT_I,
    output logic [1:0] MODE_O,
    output logic [STAT_W-1:0] SUPPLY_STATUS_FIELD_O,
    output logic SUPPLY_EVENT_O,
    output logic BATTERY_SELECT_O,
    output logic DIGITAL_SUPPLY_RAIL_EN_O,
    output logic MPU_RUN_O,
    output logic MPU_RESTART_O,
    output logic PERIPH_EN_O,
    output logic CE_RUN_O,
    output logic PLL_FAST_O,
    output logic WAKE_O,
    output logic WDT_RESET_O,
    output logic [SEG_W-1:0] SEGMENT_DATA_REGS_O,
    output logic BLINK_SEGMENT_A_O,
    output logic BLINK_SEGMENT_B_O
);
    mode_t mode_q;
    mode_t mode_d;
    logic bat_q;
    logic evt_q;
    logic restart_q;
    logic [STAT_W-1:0] field_q;
    logic [CTL_W-1:0] ctrl_q;
    logic [EV_W-1:0] ev_q;
    logic [WAKE_SRC_W-1:0] src_q;
    logic [SEG_W-1:0] seg_q;
    logic [TMR_W-1:0] tmr_load_q;
    logic [TMR_W-1:0] tmr_cnt_q;
    logic [CNT_W-1:0] tick_q;
    logic [CNT_W-1:0] blink_q;
    logic phase_q;
    logic [DATA_W-1:0] prdata_q;

    pmc_wake_if wif();

    wake_capture u_wake
    (
        .clk_i(CLK_I),
        .rst_n_i(NRST_I),
        .supply_pin_i(SUPPLY_GOOD_I),
        .pins_i({OPTICAL_RECEIVE_INPUT_I, SERIAL_RX_I, WAKE_PIN_C_I,
                 WAKE_PIN_B_I, WAKE_PIN_A_I, PUSH_BUTTON_WAKE_I}),
        .wif(wif.capture)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register bus decode.
    logic apb_setup;
    logic apb_access;
    logic apb_write;
    logic sel_ctrl;
    logic sel_status;
    logic sel_event;
    logic sel_seg;
    logic sel_timer;
    logic addr_hit;
    logic wr_ctrl;
    logic wr_event;
    logic wr_seg;
    logic wr_timer;
    logic [DATA_W-1:0] status_w;
    logic [DATA_W-1:0] rdata_w;

    assign apb_setup = PSEL_I && !PENABLE_I;
    assign apb_access = PSEL_I && PENABLE_I;
    assign apb_write = apb_access && PWRITE_I;
    assign sel_ctrl = PADDR_I == CTRL_OFS;
    assign sel_status = PADDR_I == STATUS_OFS;
    assign sel_event = PADDR_I == EVENT_OFS;
    assign sel_seg = PADDR_I == SEG_OFS;
    assign sel_timer = PADDR_I == TIMER_OFS;
    assign addr_hit = sel_ctrl | sel_status | sel_event | sel_seg | sel_timer;
    assign wr_ctrl = apb_write && sel_ctrl;
    assign wr_event = apb_write && sel_event;
    assign wr_seg = apb_write && sel_seg;
    assign wr_timer = apb_write && sel_timer;

    // Status layout, low to high: mode, status field, supply good, last wake.
    assign status_w = DATA_W'({src_q, wif.supply_good, field_q, mode_q});
    assign rdata_w = ({DATA_W{sel_ctrl}} & DATA_W'(ctrl_q))
                   | ({DATA_W{sel_status}} & status_w)
                   | ({DATA_W{sel_event}} & DATA_W'(ev_q))
                   | ({DATA_W{sel_seg}} & seg_q)
                   | ({DATA_W{sel_timer}} & DATA_W'(tmr_load_q));

    // Zero wait states: read data is captured in the setup cycle.
    assign PREADY_O = 1'h1;
    assign PSLVERR_O = apb_access && !addr_hit;
    assign PRDATA_O = prdata_q;

    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            prdata_q <= '0;
        else if (apb_setup && !PWRITE_I)
            prdata_q <= addr_hit ? rdata_w : '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode sequencing.
    logic good;
    logic low_q;
    logic low_d;
    logic enter_low;
    logic leave_low;
    logic lost_w;
    logic back_w;
    logic sleep_req;
    logic disp_req;
    logic woke_w;

    assign good = wif.supply_good;
    assign low_q = mode_q[MODE_LOW_BIT];
    assign low_d = mode_d[MODE_LOW_BIT];
    assign enter_low = !low_q && low_d;
    assign leave_low = low_q && !low_d;
    assign sleep_req = ctrl_q[CTL_SLEEP_BIT];
    assign disp_req = ctrl_q[CTL_DISPLAY_BIT];
    assign woke_w = |wif.pending_src;
    assign lost_w = !bat_q && !good;
    assign back_w = bat_q && good;
    assign wif.arm = low_q;

    always_comb
    begin
        mode_d = mode_q;
        case (mode_q)
            MODE_MISSION:
            begin
                if (!good)
                    mode_d = MODE_BROWNOUT;
                else if (sleep_req)
                    mode_d = MODE_SLEEP;
                else if (disp_req)
                    mode_d = MODE_DISPLAY;
            end
            MODE_BROWNOUT:
            begin
                if (good)
                    mode_d = MODE_MISSION;
                else if (sleep_req)
                    mode_d = MODE_SLEEP;
                else if (disp_req)
                    mode_d = MODE_DISPLAY;
            end
            MODE_DISPLAY, MODE_SLEEP:
            begin
                // Only power return or a wake source ends low power.
                if (good)
                    mode_d = MODE_MISSION;
                else if (woke_w)
                    mode_d = MODE_BROWNOUT;
            end
            default:
                mode_d = MODE_MISSION;
        endcase
    end

    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            mode_q <= MODE_MISSION;
            bat_q <= 1'h0;
            field_q <= STAT_SYSTEM;
            evt_q <= 1'h0;
            restart_q <= 1'h0;
        end
        else
        begin
            mode_q <= mode_d;
            bat_q <= lost_w ? 1'h1 : (back_w ? 1'h0 : bat_q);
            field_q <= lost_w ? STAT_BATTERY : (back_w ? STAT_SYSTEM : field_q);
            evt_q <= lost_w | back_w;
            restart_q <= leave_low;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control, event, wake source, segment and timer registers.
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;

    assign ev_set = {leave_low, back_w, lost_w};
    assign ev_clr = wr_event ? PWDATA_I[EV_W-1:0] : '0;

    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            ctrl_q <= CTRL_RESET;
        else if (leave_low)
            ctrl_q <= CTRL_RESET;
        else if (wr_ctrl)
            ctrl_q <= PWDATA_I[CTL_W-1:0];
    end

    // A new event in the clearing cycle survives the write of one.
    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            ev_q <= '0;
        else
            ev_q <= (ev_q & ~ev_clr) | ev_set;
    end

    // Segment and timer data are kept across low power like nonvolatile state.
    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            src_q <= '0;
            seg_q <= '0;
            tmr_load_q <= '0;
        end
        else
        begin
            src_q <= leave_low ? wif.pending_src : src_q;
            seg_q <= wr_seg ? PWDATA_I : seg_q;
            tmr_load_q <= wr_timer ? PWDATA_I[TMR_W-1:0] : tmr_load_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake timer in millisecond ticks; a load of zero disables it.
    logic tick_w;

    assign tick_w = tick_q == CNT_W'(TICK_CYCLES - 1);
    assign wif.timer_expired = low_q && tick_w && (tmr_cnt_q == TMR_LAST);

    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            tick_q <= '0;
        else if (!low_q || tick_w)
            tick_q <= '0;
        else
            tick_q <= tick_q + 1'h1;
    end

    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            tmr_cnt_q <= '0;
        else if (enter_low)
            tmr_cnt_q <= tmr_load_q;
        else if (low_q && tick_w && (tmr_cnt_q != '0))
            tmr_cnt_q <= tmr_cnt_q - 1'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Blink phase runs freely so display-only mode needs no MPU help.
    logic blink_end;
    logic in_display;

    assign blink_end = blink_q == CNT_W'(BLINK_HALF_CYCLES - 1);
    assign in_display = mode_q == MODE_DISPLAY;

    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            blink_q <= '0;
            phase_q <= 1'h0;
        end
        else
        begin
            blink_q <= blink_end ? '0 : blink_q + 1'h1;
            phase_q <= blink_end ? !phase_q : phase_q;
        end
    end

    assign BLINK_SEGMENT_A_O = seg_q[BLINK_A_IDX]
        & !(in_display && ctrl_q[CTL_BLINK_A_BIT] && phase_q);
    assign BLINK_SEGMENT_B_O = seg_q[BLINK_B_IDX]
        & !(in_display && ctrl_q[CTL_BLINK_B_BIT] && phase_q);

    ////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign MODE_O = mode_q;
    assign SUPPLY_STATUS_FIELD_O = field_q;
    assign SUPPLY_EVENT_O = evt_q;
    assign BATTERY_SELECT_O = bat_q;
    assign DIGITAL_SUPPLY_RAIL_EN_O = !low_q;
    assign MPU_RUN_O = !low_q;
    assign MPU_RESTART_O = restart_q;
    assign PERIPH_EN_O = !low_q;
    assign CE_RUN_O = ctrl_q[CTL_CE_RUN_BIT];
    assign PLL_FAST_O = ctrl_q[CTL_PLL_FAST_BIT];
    assign WAKE_O = !low_q;
    assign WDT_RESET_O = !WAKE_O;
    assign SEGMENT_DATA_REGS_O = seg_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!NRST_I);

    sequence s_sleep_request;
        mode_q == MODE_MISSION && good && sleep_req;
    endsequence

    sequence s_sleep_bounce;
        (mode_q == MODE_SLEEP && !WAKE_O && good) ##1 (mode_q == MODE_MISSION);
    endsequence

    a_power_return: assert property (
        (good && mode_q != MODE_MISSION) |=> (mode_q == MODE_MISSION))
        else $error("no return to mission with supply good");

    a_supply_loss: assert property (
        lost_w |=> (bat_q && field_q == STAT_BATTERY && SUPPLY_EVENT_O
                    && ev_q[EV_LOST_BIT] && mode_q != MODE_MISSION))
        else $error("supply loss not reported");

    a_brownout_keeps: assert property (
        (mode_q == MODE_MISSION && mode_d == MODE_BROWNOUT)
        |=> (MPU_RUN_O && !MPU_RESTART_O && $stable(PLL_FAST_O) && $stable(CE_RUN_O)))
        else $error("brownout entry disturbed MPU or clocks");

    a_brownout_alive: assert property (
        (mode_q == MODE_BROWNOUT) |-> (PERIPH_EN_O && DIGITAL_SUPPLY_RAIL_EN_O))
        else $error("peripherals off in brownout");

    a_low_entry: assert property (
        (mode_q == MODE_BROWNOUT && !good && (sleep_req || disp_req))
        |=> (mode_q == (sleep_req ? MODE_SLEEP : MODE_DISPLAY)))
        else $error("low power request not taken");

    a_mission_sleep: assert property (
        (s_sleep_request ##1 good) |-> s_sleep_bounce)
        else $error("sleep with supply did not bounce");

    a_display_bounce: assert property (
        (mode_q == MODE_MISSION && good && !sleep_req && disp_req ##1 good)
        |-> (mode_q == MODE_DISPLAY) ##1 (mode_q == MODE_MISSION && MPU_RESTART_O))
        else $error("display-only from mission did not wake");

    a_low_rails: assert property (
        low_q |-> (!DIGITAL_SUPPLY_RAIL_EN_O && !MPU_RUN_O && WDT_RESET_O))
        else $error("rail or MPU on in low power");

    a_wake_exit: assert property (
        (low_q && !good && woke_w)
        |=> (mode_q == MODE_BROWNOUT && MPU_RESTART_O && ctrl_q == CTRL_RESET
             && ev_q[EV_WOKE_BIT]) ##1 !MPU_RESTART_O)
        else $error("wake exit incomplete");

    a_sleep_hold: assert property (
        (mode_q == MODE_SLEEP && !good && !woke_w) |=> (mode_q == MODE_SLEEP))
        else $error("sleep left without cause");

    a_blink_phase: assert property (
        (in_display && ctrl_q[CTL_BLINK_A_BIT] && seg_q[BLINK_A_IDX])
        |-> (BLINK_SEGMENT_A_O == !phase_q))
        else $error("blink segment a wrong");
endmodule

// ---- pmc_far_side.sv ----
/*
 * Far-side model: the supply comparator and the wake pins.
 * Assumes the bench raises pulse_i bits for a few cycles to make a wake event.
 */
`timescale 1ns/1ps
module pmc_far_side
    import pmc_pkg::*;
(
    input wire logic clk_i,
    input wire logic supply_on_i,
    input wire logic [PIN_W-1:0] pulse_i,
    output logic supply_o,
    output logic [PIN_W-1:0] pins_o
);
    initial pins_o = '0;
    initial supply_o = 1'b1;
    // Serial inputs toggle, so only a change is ever shown, not a level.
    always @(posedge clk_i)
    begin
        supply_o <= supply_on_i;
        pins_o <= ((pins_o ^ pulse_i) & ~RISING_MASK) | (pulse_i & RISING_MASK);
    end
endmodule

// ---- tb_top.sv ----
/*
 * Self-checking bench of the power mode controller.
 * Assumes the design answers APB with no wait states and short sim counts.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("Error %0t: got %h expected %h", $time, g, e); end end
module tb_top
    import pmc_pkg::*;
;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, q, seg;
    logic pready, pslverr, ev, bat, rail, mpu, rst_o, periph, ce, pll, wake, wdt, bla, blb;
    logic supply_on = 1'b1, supply, err;
    logic [PIN_W-1:0] pulse = '0, pins;
    logic [1:0] mode;
    logic [STAT_W-1:0] stat;
    int failures = 0, tests_run = 0, ev_cnt = 0, rs_cnt = 0, ev0, rs0, n0, n1;
    always #2 clk = ~clk;
    always @(posedge clk)
    begin
        if (ev === 1'b1) ev_cnt++;
        if (rst_o === 1'b1) rs_cnt++;
    end
    power_mode_controller #(.TICK_CYCLES(4), .BLINK_HALF_CYCLES(8)) u_power_mode_controller (
        .CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .SUPPLY_GOOD_I(supply), .PUSH_BUTTON_WAKE_I(pins[0]),
        .WAKE_PIN_A_I(pins[1]), .WAKE_PIN_B_I(pins[2]), .WAKE_PIN_C_I(pins[3]),
        .SERIAL_RX_I(pins[4]), .OPTICAL_RECEIVE_INPUT_I(pins[5]), .MODE_O(mode),
        .SUPPLY_STATUS_FIELD_O(stat), .SUPPLY_EVENT_O(ev), .BATTERY_SELECT_O(bat),
        .DIGITAL_SUPPLY_RAIL_EN_O(rail), .MPU_RUN_O(mpu), .MPU_RESTART_O(rst_o),
        .PERIPH_EN_O(periph), .CE_RUN_O(ce), .PLL_FAST_O(pll), .WAKE_O(wake),
        .WDT_RESET_O(wdt), .SEGMENT_DATA_REGS_O(seg), .BLINK_SEGMENT_A_O(bla),
        .BLINK_SEGMENT_B_O(blb));
    pmc_far_side u_pmc_far_side (.clk_i(clk), .supply_on_i(supply_on), .pulse_i(pulse),
        .supply_o(supply), .pins_o(pins));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Nothing here bounds this wait; the watchdog ends a stuck one, so a stuck slave still reaches the verdict.
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        `CHK(pready, 1'b1)
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [DATA_W-1:0] ctl(input int b);
        return DATA_W'(CTRL_RESET) | (32'h1 << b);
    endfunction
    task automatic wait_mode(input mode_t m);
        for (int i = 0; i < 100 && mode !== m; i++) @(posedge clk);
        @(posedge clk);
        `CHK(mode, m)
    endtask
    task automatic complete_run();
        if (failures == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `CHK(mode, MODE_MISSION)
        `CHK({stat, bat, rail, wdt}, {STAT_SYSTEM, 3'b010})
        apb(1'b0, CTRL_OFS, '0);
        `CHK(q[CTL_W-1:0], CTRL_RESET)
        apb(1'b0, 8'h40, '0);
        `CHK({q, err}, {32'h0, 1'b1})
        apb(1'b1, TIMER_OFS, '0);
        apb(1'b1, SEG_OFS, 32'hA5C3_0F03);
        // The write lands at the access edge, so look one edge later.
        @(posedge clk);
        `CHK(seg, 32'hA5C3_0F03)
    endtask
    task automatic t_loss();
        ev0 = ev_cnt;
        supply_on <= 1'b0;
        wait_mode(MODE_BROWNOUT);
        `CHK(ev_cnt, ev0 + 1)
        `CHK({bat, stat}, {1'b1, STAT_BATTERY})
        `CHK({mpu, ce, pll, periph, rail}, 5'h1F)
        apb(1'b0, STATUS_OFS, '0);
        `CHK(q[5:0], {1'b0, STAT_BATTERY, MODE_BROWNOUT})
        apb(1'b0, EVENT_OFS, '0);
        `CHK(q[EV_LOST_BIT], 1'b1)
        apb(1'b1, EVENT_OFS, 32'h7);
        apb(1'b0, EVENT_OFS, '0);
        `CHK(q[EV_W-1:0], 3'h0)
    endtask
    task automatic t_wake();
        logic [DATA_W-1:0] cw;
        for (int i = 0; i < PIN_W; i++)
        begin
            cw = ctl(i[0] ? CTL_SLEEP_BIT : CTL_DISPLAY_BIT) | (i == 2 ? 32'h30 : 32'h10);
            cw[CTL_PLL_FAST_BIT] = 1'b0;
            apb(1'b1, CTRL_OFS, cw);
            wait_mode(i[0] ? MODE_SLEEP : MODE_DISPLAY);
            `CHK({rail, mpu, wake, wdt, pll}, 5'h02)
            n0 = 0;
            n1 = 0;
            repeat (32)
            begin
                @(posedge clk);
                if (bla === 1'b0) n0++;
                if (blb === 1'b0) n1++;
            end
            `CHK({n0 > 0, n1 > 0}, {!i[0], i == 2})
            rs0 = rs_cnt;
            pulse[i] <= 1'b1;
            repeat (3) @(posedge clk);
            pulse <= '0;
            wait_mode(MODE_BROWNOUT);
            `CHK(rs_cnt, rs0 + 1)
            apb(1'b0, STATUS_OFS, '0);
            `CHK(q[11:6], 6'h1 << (i == 5 ? 5 : i + 1))
            apb(1'b0, CTRL_OFS, '0);
            `CHK(q[CTL_W-1:0], CTRL_RESET)
        end
    endtask
    task automatic t_timer_return();
        apb(1'b1, TIMER_OFS, 32'h2);
        apb(1'b1, CTRL_OFS, ctl(CTL_SLEEP_BIT));
        wait_mode(MODE_SLEEP);
        repeat (3) @(posedge clk);
        `CHK(mode, MODE_SLEEP)
        wait_mode(MODE_BROWNOUT);
        apb(1'b0, STATUS_OFS, '0);
        `CHK(q[11:6], 6'h01)
        apb(1'b1, TIMER_OFS, '0);
        apb(1'b1, CTRL_OFS, ctl(CTL_SLEEP_BIT));
        wait_mode(MODE_SLEEP);
        ev0 = ev_cnt;
        supply_on <= 1'b1;
        wait_mode(MODE_MISSION);
        `CHK(ev_cnt, ev0 + 1)
        `CHK({bat, stat, rail}, {1'b0, STAT_SYSTEM, 1'b1})
        // Firmware restores mission settings after the return.
        apb(1'b1, CTRL_OFS, DATA_W'(CTRL_RESET));
        @(posedge clk);
        `CHK({ce, pll, mode}, {2'b11, MODE_MISSION})
    endtask
    task automatic t_bounce();
        for (int b = 0; b < 2; b++)
        begin
            rs0 = rs_cnt;
            ev0 = ev_cnt;
            apb(1'b1, EVENT_OFS, 32'h7);
            apb(1'b1, CTRL_OFS, ctl(b));
            for (int i = 0; i < 50 && rs_cnt == rs0; i++) @(posedge clk);
            @(posedge clk);
            `CHK({mode, rs_cnt - rs0, ev_cnt - ev0}, {MODE_MISSION, 32'h1, 32'h0})
            apb(1'b0, EVENT_OFS, '0);
            `CHK(q[EV_WOKE_BIT], 1'b1)
        end
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_loss();
        t_wake();
        t_timer_return();
        t_bounce();
        complete_run();
    end
    initial
    begin
        #50us;
        failures++;
        complete_run();
    end
endmodule
